/* File: lsfs_cfg.svh */
`ifndef LSFS_CFG_SVH
`define LSFS_CFG_SVH

// Number of LED strings
`define LSFS_NUM_CH         4
// Short debounce: more than this many switching periods
`define LSFS_SHORT_PERIODS  10000
// Debounce counter width
`define LSFS_CNT_W          14
// Sync stages for comparator flags
`define LSFS_SYNC_STAGES    2

`endif

/* File: lsfs_pkg.sv */
`default_nettype none
package lsfs_pkg;

    // Comparator flags from the analog side, per channel and shared
    typedef struct packed {
        logic [3:0] ch_ov_low;   // Channel sense above lower threshold
        logic [3:0] ch_ov_high;  // Channel sense above upper threshold
        logic [3:0] ch_low;      // Channel sense below open threshold
        logic       ovp_low;     // Overvoltage node below bottom threshold
        logic       ovp_reg;     // Overvoltage node above regulation level
        logic       ovp_rel;     // Overvoltage node above release level
        logic       ovp_crit;    // Overvoltage node above latch level
        logic       cs_limit;    // Switch current above cycle limit
        logic       cs_short;    // Switch current above inductor short
        logic       temp_hot;    // Die above shutdown temperature
        logic       temp_cool;   // Die below recovery temperature
    } lsfs_cmp_t;

    // Drive outputs
    typedef struct packed {
        logic       boost_en;    // Boost switching allowed
        logic       softstart;   // Soft-start request pulse
        logic       on_kill;     // End present on-time
        logic [3:0] sink_en;     // LED current sink enables
        logic [3:0] reg_sel;     // Channels in lowest-voltage selection
        logic [3:0] marked_off;  // Mark-off latches
    } lsfs_drv_t;

endpackage : lsfs_pkg
`default_nettype wire

/* File: lsfs_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsfs_cfg.svh"

module lsfs_supervisor #(
    parameter int CNT_W = `LSFS_CNT_W,
    parameter int SHORT_PERIODS = `LSFS_SHORT_PERIODS
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Enable pin and comparators
    input  wire logic              enable_i,
    input  wire lsfs_pkg::lsfs_cmp_t cmp_i,
    // Drives
    output var  lsfs_pkg::lsfs_drv_t drv_o
);

    // ****************************************************
    // State
    // ****************************************************
    typedef enum logic [1:0] {
        LSFS_OFF,
        LSFS_RUN,
        LSFS_HOT
    } lsfs_mode_t;

    typedef struct packed {
        lsfs_pkg::lsfs_cmp_t   s1;      // First sync stage
        lsfs_pkg::lsfs_cmp_t   s2;      // Second sync stage
        logic                  en1;     // Enable sync stage 1
        logic                  en2;     // Enable sync stage 2
        logic                  en3;     // Enable delayed for edge
        lsfs_mode_t            mode;    // Run mode
        logic                  ovp_hold;// Regulation pause latch
        logic                  crit;    // Latched shutdown
        logic [3:0]            mark;    // Mark-off latches
        logic [3:0][CNT_W-1:0] cnt;     // Debounce counters
        lsfs_pkg::lsfs_drv_t   drv;     // Registered outputs
    } lsfs_state_t;

    lsfs_state_t st_ff;      // Registered state
    lsfs_state_t nxt_st;     // Next state
    logic        en_rise;    // Enable rising edge, clears latches
    logic [3:0]  mark_set;   // Mark-off requests this cycle
    logic        crit_set;   // Latched-shutdown request this cycle

    localparam logic [CNT_W-1:0] TERM = CNT_W'(SHORT_PERIODS);

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        logic open_ok;
        logic run_ok;
        open_ok  = 1'b0;
        run_ok   = 1'b0;
        en_rise  = 1'b0;
        mark_set = 4'h0;
        crit_set = 1'b0;
        nxt_st   = st_ff;
        // Synchronizers
        nxt_st.s1  = cmp_i;
        nxt_st.s2  = st_ff.s1;
        nxt_st.en1 = enable_i;
        nxt_st.en2 = st_ff.en1;
        nxt_st.en3 = st_ff.en2;
        en_rise = st_ff.en2 & ~st_ff.en3;
        // Enable rise clears latches first: a fault present in
        // the same cycle sets its latch again and is not lost
        if (en_rise) begin
            nxt_st.mark = '0;
            nxt_st.crit = 1'b0;
        end
        // Open detection when limit reached
        open_ok = st_ff.s2.ovp_reg | st_ff.s2.cs_limit;
        for (int i = 0; i < 4; i++) begin
            // Debounce: count while over, restart on drop
            if (!st_ff.s2.ch_ov_low[i]) begin
                nxt_st.cnt[i] = '0;
            end else if (st_ff.cnt[i] != TERM) begin
                nxt_st.cnt[i] = st_ff.cnt[i] + CNT_W'(1);
            end
            if (st_ff.cnt[i] == TERM && st_ff.s2.ch_ov_low[i]) begin
                mark_set[i] = 1'b1;
            end
            if (st_ff.s2.ch_ov_high[i]) begin
                mark_set[i] = 1'b1;
            end
            if (st_ff.s2.ch_low[i] && open_ok && st_ff.mode == LSFS_RUN
                && !st_ff.s2.ovp_low) begin
                mark_set[i] = 1'b1;
            end
        end
        // Sets win over the enable-rise clear
        nxt_st.mark = nxt_st.mark | mark_set;
        // Regulation pause with hysteresis
        if (st_ff.s2.ovp_reg) begin
            nxt_st.ovp_hold = 1'b1;
        end else if (!st_ff.s2.ovp_rel) begin
            nxt_st.ovp_hold = 1'b0;
        end
        // Latched shutdowns, set wins over the clear
        crit_set = st_ff.s2.ovp_crit | st_ff.s2.cs_short;
        if (crit_set) begin
            nxt_st.crit = 1'b1;
        end
        // Counters restart on enable rise
        if (en_rise) begin
            nxt_st.cnt = '0;
        end
        // Mode
        nxt_st.drv.softstart = 1'b0;
        unique case (st_ff.mode)
            LSFS_OFF: begin
                if (st_ff.en2) begin
                    nxt_st.mode = LSFS_RUN;
                    nxt_st.drv.softstart = 1'b1;
                end
            end
            LSFS_RUN: begin
                if (!st_ff.en2) begin
                    nxt_st.mode = LSFS_OFF;
                end else if (st_ff.s2.temp_hot) begin
                    nxt_st.mode = LSFS_HOT;
                end
            end
            LSFS_HOT: begin
                if (!st_ff.en2) begin
                    nxt_st.mode = LSFS_OFF;
                end else if (st_ff.s2.temp_cool) begin
                    nxt_st.mode = LSFS_RUN;
                    nxt_st.drv.softstart = 1'b1;
                end
            end
            // Unused code falls back to off
            default: begin
                nxt_st.mode = LSFS_OFF;
            end
        endcase
        // Outputs
        run_ok = st_ff.mode == LSFS_RUN && !st_ff.crit
                 && !st_ff.s2.ovp_low && !st_ff.s2.temp_hot;
        nxt_st.drv.marked_off = nxt_st.mark;
        nxt_st.drv.reg_sel    = ~nxt_st.mark;
        nxt_st.drv.sink_en    = run_ok ? ~nxt_st.mark : 4'h0;
        nxt_st.drv.boost_en   = run_ok && !nxt_st.ovp_hold
                                && !st_ff.s2.ovp_reg
                                && (nxt_st.mark != 4'hf);
        nxt_st.drv.on_kill    = st_ff.s2.cs_limit;
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign drv_o = st_ff.drv;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Mark latch holds unless the enable rises
    mark_holds_a: assert property (
        st_ff.mark[0] && !en_rise |=> st_ff.mark[0])
        else $error("mark dropped");
    // Upper threshold marks with no debounce
    high_mark_a: assert property (
        st_ff.s2.ch_ov_high[1] |=> st_ff.mark[1])
        else $error("upper mark late");
    // Terminal count with comparator high marks
    deb_mark_a: assert property (
        st_ff.s2.ch_ov_low[0] && st_ff.cnt[0] == TERM |=> st_ff.mark[0])
        else $error("debounce mark missing");
    // Counter restarts when comparator drops
    deb_reset_a: assert property (
        !st_ff.s2.ch_ov_low[0] |=> st_ff.cnt[0] == '0)
        else $error("counter not cleared");
    // No boost with every string marked
    all_off_a: assert property (
        st_ff.mark == 4'hf |=> !drv_o.boost_en)
        else $error("boost with all marked");
    // Marked string has its sink off
    sink_mark_a: assert property (
        st_ff.mark[3] |=> !drv_o.sink_en[3])
        else $error("sink on while marked");
    // Marked string shown and out of the selection
    sel_mark_a: assert property (
        st_ff.mark[1] |-> drv_o.marked_off[1] && !drv_o.reg_sel[1])
        else $error("marked in selection");
    // Critical node keeps boost and sinks off
    crit_off_a: assert property (
        st_ff.s2.ovp_crit ##1 !en_rise
        |=> drv_o.sink_en == 4'h0 && !drv_o.boost_en)
        else $error("critical not latched");
    // Node near ground holds boost and sinks off
    low_node_a: assert property (
        st_ff.s2.ovp_low |=> !drv_o.boost_en && drv_o.sink_en == 4'h0)
        else $error("node low not off");
    // Current limit ends the on-time
    ilim_kill_a: assert property (
        st_ff.s2.cs_limit |=> drv_o.on_kill)
        else $error("on-time not ended");
    // Enable rise leaves only the faults seen in that cycle
    en_clear_a: assert property (
        en_rise |=> st_ff.mark == $past(mark_set)
            && st_ff.crit == $past(crit_set))
        else $error("enable rise no clear");

    cov_debounce_c: cover property (st_ff.cnt[0] == TERM ##1 st_ff.mark[0]);
    cov_all_off_c: cover property (st_ff.mark == 4'hf);
    cov_hot_c: cover property (
        st_ff.mode == LSFS_HOT ##1 st_ff.mode == LSFS_RUN);
    cov_open_c: cover property (
        st_ff.s2.cs_limit && st_ff.s2.ch_low != 4'h0 ##1 st_ff.mark != 4'h0);

endmodule : lsfs_supervisor
`default_nettype wire

/* File: lsfs_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Analog comparators at the far side
// ************************************
module lsfs_analog_model (
    // Pin levels in mV and degrees C
    input  var int                  ch_mv_i [4],
    input  var int                  ovp_mv_i,
    input  var int                  cs_mv_i,
    input  var int                  tj_c_i,
    // Comparator flags to the block
    output var lsfs_pkg::lsfs_cmp_t cmp_o
);
    // Plain threshold compares, no hysteresis of their own
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp_o.ch_ov_low[i]  = ch_mv_i[i] > 8700;
            cmp_o.ch_ov_high[i] = ch_mv_i[i] > 16200;
            cmp_o.ch_low[i]     = ch_mv_i[i] < 100;
        end
        cmp_o.ovp_low   = ovp_mv_i < 100;
        cmp_o.ovp_reg   = ovp_mv_i > 2000;
        cmp_o.ovp_rel   = ovp_mv_i > 1900;
        cmp_o.ovp_crit  = ovp_mv_i > 3200;
        cmp_o.cs_limit  = cs_mv_i > 500;
        cmp_o.cs_short  = cs_mv_i > 1500;
        cmp_o.temp_hot  = tj_c_i > 150;
        cmp_o.temp_cool = tj_c_i < 120;
    end
endmodule : lsfs_analog_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Supervisor bench
// ****************
module testbench;
    logic                clk_i = 1'b0;     // Switching clock
    logic                resetn_i = 1'b0;  // Power-on reset
    logic                enable_i = 1'b0;  // Enable pin
    int                  ch [4] = '{500, 500, 500, 500};
    int                  overvoltage_sense_node = 1500;       // Node in mV
    int                  cs = 200;         // Switch sense in mV
    int                  tj = 50;          // Die temperature
    int                  mismatches = 0;
    int                  check_count = 0;
    int                  n;                // Pulse counter
    lsfs_pkg::lsfs_cmp_t cmp;
    lsfs_pkg::lsfs_drv_t drv;
    // Far side and block
    lsfs_analog_model fe (.ch_mv_i(ch), .ovp_mv_i(overvoltage_sense_node), .cs_mv_i(cs),
        .tj_c_i(tj), .cmp_o(cmp));
    lsfs_supervisor #(.CNT_W(14), .SHORT_PERIODS(8)) uut (.clk_i(clk_i),
        .resetn_i(resetn_i), .enable_i(enable_i), .cmp_i(cmp), .drv_o(drv));
    // 100 ns clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic w(input int k);
        repeat (k) @(negedge clk_i);
    endtask : w
    task automatic chk(input string nm, input logic [3:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Boost, sinks and marks together; selection mirrors marks
    task automatic st(input logic b, input logic [3:0] s, m);
        chk("boost_en", {3'h0, drv.boost_en}, {3'h0, b});
        chk("sink_en", drv.sink_en, s);
        chk("marked_off", drv.marked_off, m);
        chk("reg_sel", drv.reg_sel, ~m);
    endtask : st
    // Enable toggle restart
    task automatic restart();
        enable_i = 1'b0;
        w(4);
        enable_i = 1'b1;
        w(8);
    endtask : restart
    task automatic t_marks();
        // Five, gap, seven: only a restarted count stays unmarked
        ch[0] = 9000; w(5); ch[0] = 500; w(3); ch[0] = 9000; w(7);
        st(1'b1, 4'hf, 4'h0);
        w(12); ch[0] = 500; w(4);
        st(1'b1, 4'he, 4'h1);
        ch[1] = 17000; w(4); ch[1] = 500;
        st(1'b1, 4'hc, 4'h3);
        overvoltage_sense_node = 2100; ch[2] = 50; w(4);
        st(1'b0, 4'h8, 4'h7);
        overvoltage_sense_node = 1950; ch[2] = 500; w(4);
        st(1'b0, 4'h8, 4'h7);
        overvoltage_sense_node = 1500; w(4);
        st(1'b1, 4'h8, 4'h7);
        ch[3] = 17000; w(4); ch[3] = 500; w(2);
        st(1'b0, 4'h0, 4'hf);
        restart();
        st(1'b1, 4'hf, 4'h0);
    endtask : t_marks
    task automatic t_node();
        overvoltage_sense_node = 50; w(4);
        st(1'b0, 4'h0, 4'h0);
        overvoltage_sense_node = 1500; w(4);
        st(1'b1, 4'hf, 4'h0);
        overvoltage_sense_node = 3300; w(4); overvoltage_sense_node = 1500; w(4);
        st(1'b0, 4'h0, 4'h0);
        restart();
        st(1'b1, 4'hf, 4'h0);
    endtask : t_node
    task automatic t_heat_cs();
        tj = 160; w(4); tj = 130; w(4);
        st(1'b0, 4'h0, 4'h0);
        tj = 100; n = 0;
        repeat (8) begin
            w(1); n += int'(drv.softstart);
        end
        chk("softstart", n[3:0], 4'h1);
        st(1'b1, 4'hf, 4'h0);
        cs = 600; w(4);
        chk("on_kill", {3'h0, drv.on_kill}, 4'h1);
        chk("sink_en", drv.sink_en, 4'hf);
        cs = 200; w(4);
        chk("on_kill", {3'h0, drv.on_kill}, 4'h0);
        // Current limit alone marks an open string
        cs = 600; ch[0] = 50; w(4); cs = 200; ch[0] = 500;
        chk("marked_off", drv.marked_off, 4'h1);
        cs = 1600; w(4); cs = 200; ch[1] = 17000; w(4); ch[1] = 500;
        st(1'b0, 4'h0, 4'h3);
        // Marks gone before the enable rise is seen again
        resetn_i = 1'b0; w(2); resetn_i = 1'b1; w(1);
        st(1'b0, 4'h0, 4'h0);
        w(7);
        st(1'b1, 4'hf, 4'h0);
    endtask : t_heat_cs
    task automatic conclude();
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        w(2); resetn_i = 1'b1; enable_i = 1'b1; w(8);
        t_marks();
        t_node();
        t_heat_cs();
        conclude();
    end
    // Watchdog well beyond the run
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
